/* File: alarm_relay_sequencer.sv */
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
module alarm_relay_sequencer
   import alarm_pkg::*;
#(
   parameter int NRLY = 4,
   parameter int NLINE = 2,
   parameter int LEVELS = 4,
   parameter int MS_CYCLES = 100000
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Operator controls
   input wire logic [1:0] selector_i,
   input wire logic ctrl_reset_btn_i,
   input wire logic ack_local_i,
   input wire logic ack_remote_closed_i,
   input wire logic shown_chan_alarm_i,
   // Detection events
   input wire logic [(2**LEVELS)-1:0] alarm_evt_i,
   input wire logic [(2**LEVELS)-1:0] fault_evt_i,
   // Communication lines
   input wire logic [NLINE-1:0] line_present_i,
   input wire logic [NLINE-1:0] line_fail_i,
   input wire logic [NLINE-1:0] line_poor_i,
   input wire logic [NLINE-1:0] line_tx_act_i,
   input wire logic [NLINE-1:0] line_rx_act_i,
   // Relays and indicators
   output logic [NRLY-1:0] relay_coil_o,
   output logic [NRLY-1:0] relay_led_o,
   output logic fault_relay_o,
   output logic buzzer_o,
   output logic fail_led_o,
   output logic grayscale_o,
   output logic [1:0] mode_o,
   output logic [NLINE-1:0] line_tx_led_o,
   output logic [NLINE-1:0] line_rx_led_o
);
   localparam int NEV = 2**LEVELS;
   localparam int NNODE = NEV - 1;

   // Refuse sizes the register map and gate tree cannot hold
   if (NRLY < 1 || NRLY > 4 || NLINE < 1 || NLINE > 2 || LEVELS < 1 || LEVELS > 4 || MS_CYCLES < 1) begin : g_bad_param
      $error("alarm_relay_sequencer: unsupported parameter values");
   end

   // ----------------------------------------
   // Reset, mode and acknowledge
   // ----------------------------------------
   logic rst;
   logic [1:0] mode_r;
   logic run;
   logic cfg_wr_ok;
   logic ack_raw;
   logic ack_d_r;
   logic ack_pulse;

   assign rst = rst_i | ctrl_reset_btn_i;
   assign run = (mode_r == MODE_NORMAL);
   assign cfg_wr_ok = (mode_r == MODE_CONFIG);
   assign ack_raw = ack_local_i | ack_remote_closed_i;
   assign ack_pulse = ack_raw & ~ack_d_r;

   always_ff @(posedge clk_i) begin
      if (rst) begin
         mode_r <= MODE_NORMAL;
         ack_d_r <= 1'b0;
      end else begin
         // Position 3 is not a detent; treat it as configuration so relays freeze
         mode_r <= (selector_i == MODE_UPDATE) ? MODE_UPDATE :
                   (selector_i == MODE_NORMAL) ? MODE_NORMAL : MODE_CONFIG;
         ack_d_r <= ack_raw;
      end
   end

   // ----------------------------------------
   // Time base
   // ----------------------------------------
   logic [$clog2(MS_CYCLES+1)-1:0] div_r;
   logic [9:0] ms_r;
   logic ms_tick;
   logic sec_tick;
   logic fast_tick;
   logic slow_phase_r;
   logic [7:0] lfsr_r;

   assign ms_tick = (div_r == ($clog2(MS_CYCLES+1))'(MS_CYCLES - 1));
   assign sec_tick = ms_tick && (ms_r == 10'(MS_PER_SEC - 1));
   assign fast_tick = ms_tick && ((ms_r % 10'(FAST_BLINK_MS)) == 10'(FAST_BLINK_MS - 1));

   always_ff @(posedge clk_i) begin
      if (rst) begin
         div_r <= '0;
         ms_r <= '0;
         slow_phase_r <= 1'b0;
         lfsr_r <= LFSR_SEED;
      end else begin
         div_r <= ms_tick ? '0 : div_r + 1'b1;
         if (ms_tick) begin
            ms_r <= sec_tick ? '0 : ms_r + 10'h001;
            if (ms_r == 10'(MS_PER_SEC - 1) || ms_r == 10'(SLOW_HALF_MS - 1)) begin
               slow_phase_r <= (ms_r == 10'(SLOW_HALF_MS - 1));
            end
         end
         if (fast_tick) begin
            lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
         end
      end
   end

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   logic req;
   logic wr_req;
   logic hit_ctrl;
   logic hit_relay;
   logic [2:0] rly_idx;
   logic [4:0] rly_ofs;
   logic [31:0] ctrl_r;
   logic [31:0] status_w;
   logic [31:0] rd_relay [NRLY];
   logic [31:0] rd_data;
   logic [NRLY-1:0] active_w;
   logic any_line_fail;
   logic buzz_pend_r;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return res;
   endfunction

   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_req = req & wb_we_i & cfg_wr_ok;
   assign hit_ctrl = (wb_adr_i == CTRL_OFS);
   assign rly_idx = 3'(wb_adr_i[7:RELAY_STRIDE_LG2] - RELAY_BASE[7:RELAY_STRIDE_LG2]);
   assign rly_ofs = wb_adr_i[RELAY_STRIDE_LG2-1:0];
   assign hit_relay = (wb_adr_i >= RELAY_BASE) && (rly_idx < 3'(NRLY));
   assign status_w = {21'h0, buzz_pend_r, 2'(any_line_fail), 4'(active_w), 2'h0, mode_r};
   assign rd_data = hit_ctrl ? ctrl_r :
                    (wb_adr_i == STATUS_OFS) ? status_w :
                    hit_relay ? rd_relay[rly_idx[1:0]] : 32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         ctrl_r <= 32'h00000000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? rd_data : 32'h00000000;
         if (wr_req && hit_ctrl) begin
            ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i) & 32'h00000001;
         end
      end
   end

   // ----------------------------------------
   // Alarm relays
   // ----------------------------------------
   logic [NEV-1:0] ev_alarm;
   logic [NEV-1:0] ev_fault;

   assign ev_alarm = alarm_evt_i;
   assign ev_fault = fault_evt_i;

   for (genvar i = 0; i < NRLY; i++) begin : g_rly
      logic [31:0] cfg_r;
      logic [31:0] mask_r;
      logic [31:0] eqn_r;
      logic [31:0] tima_r;
      logic [31:0] timb_r;
      relay_state_t st_r;
      relay_state_t st_nxt;
      logic [TIM_W-1:0] tmr_r;
      logic acked_r;
      logic [NEV-1:0] ev;
      logic [NEV-1:0] leaf;
      logic [2*NEV-2:0] node;
      logic [4:0] votes;
      logic cond;
      logic sel_me;
      logic [TIM_W-1:0] t_delay;
      logic [TIM_W-1:0] t_hold;
      logic [TIM_W-1:0] t_auto;
      logic [TIM_W-1:0] t_react;
      logic hold_ok;
      logic release_ok;

      assign ev = ev_alarm | (ev_fault & {NEV{cfg_r[CFG_FAULT_CNT]}});
      assign leaf = ev & mask_r[NEV-1:0];
      assign node[2*NEV-2:NNODE] = leaf;
      // Heap-ordered gate tree: depth LEVELS gives the parenthesis nesting
      for (genvar k = 0; k < NNODE; k++) begin : g_node
         logic a;
         logic b;
         assign a = node[2*k+1];
         assign b = node[2*k+2];
         assign node[k] = (eqn_r[2*k +: 2] == OP_OR) ? (a | b) :
                          (eqn_r[2*k +: 2] == OP_AND) ? (a & b) :
                          (eqn_r[2*k +: 2] == OP_NOR) ? ~(a | b) : ~(a & b);
      end
      assign votes = 5'($countones(leaf));
      assign cond = (cfg_r[CFG_SRC_LO +: 2] == SRC_EQUATION) ? node[0] :
                    (cfg_r[CFG_SRC_LO +: 2] == SRC_VOTING) ?
                       (votes >= {1'b0, cfg_r[CFG_VOTE_LO +: 4]}) :
                    (|leaf);

      // Out-of-range settings are clamped rather than refused
      assign t_delay = tima_r[TIM_LO_LO +: TIM_W];
      assign t_hold = (tima_r[TIM_HI_LO +: TIM_W] > HOLD_MAX_S) ? HOLD_MAX_S : tima_r[TIM_HI_LO +: TIM_W];
      assign t_auto = (timb_r[TIM_LO_LO +: TIM_W] < AUTO_MIN_S) ? AUTO_MIN_S :
                      (timb_r[TIM_LO_LO +: TIM_W] > AUTO_MAX_S) ? AUTO_MAX_S : timb_r[TIM_LO_LO +: TIM_W];
      assign t_react = (timb_r[TIM_HI_LO +: TIM_W] < AUTO_MIN_S) ? AUTO_MIN_S :
                       (timb_r[TIM_HI_LO +: TIM_W] > AUTO_MAX_S) ? AUTO_MAX_S : timb_r[TIM_HI_LO +: TIM_W];
      assign hold_ok = (tmr_r >= t_hold);
      assign release_ok = hold_ok && !cond &&
                          (!cfg_r[CFG_LATCH] || ctrl_r[CTRL_AUTO_ACK] || acked_r);
      assign sel_me = wr_req && hit_relay && (rly_idx == 3'(i));
      assign active_w[i] = (st_r == RLY_ACTIVE);
      assign rd_relay[i] = (rly_ofs == CFG_OFS) ? cfg_r :
                           (rly_ofs == MASK_OFS) ? mask_r :
                           (rly_ofs == EQN_OFS) ? eqn_r :
                           (rly_ofs == TIMA_OFS) ? tima_r :
                           (rly_ofs == TIMB_OFS) ? timb_r : {30'h00000000, st_r};

      always_comb begin
         st_nxt = st_r;
         case (st_r)
            RLY_IDLE: begin
               if (cond) begin
                  st_nxt = RLY_DELAY;
               end
            end
            RLY_DELAY: begin
               if (!cond) begin
                  st_nxt = RLY_IDLE;
               end else if (tmr_r >= t_delay) begin
                  st_nxt = RLY_ACTIVE;
               end
            end
            RLY_ACTIVE: begin
               if (release_ok) begin
                  st_nxt = RLY_IDLE;
               end else if (cfg_r[CFG_BUZZER] && hold_ok && (ack_pulse || tmr_r >= t_auto)) begin
                  st_nxt = RLY_SILENT;
               end
            end
            RLY_SILENT: begin
               if (!cond) begin
                  st_nxt = RLY_IDLE;
               end else if (tmr_r >= t_react) begin
                  st_nxt = RLY_ACTIVE;
               end
            end
            default: st_nxt = RLY_IDLE;
         endcase
      end

      always_ff @(posedge clk_i) begin
         if (rst) begin
            cfg_r <= 32'h00000000;
            mask_r <= 32'h00000000;
            eqn_r <= 32'h00000000;
            tima_r <= 32'h00000000;
            timb_r <= 32'h00000000;
         end else if (sel_me) begin
            if (rly_ofs == CFG_OFS) cfg_r <= merge(cfg_r, wb_dat_i, wb_sel_i) & 32'h00000F7F;
            if (rly_ofs == MASK_OFS) mask_r <= merge(mask_r, wb_dat_i, wb_sel_i) & 32'(2**NEV - 1);
            if (rly_ofs == EQN_OFS) eqn_r <= merge(eqn_r, wb_dat_i, wb_sel_i) & 32'h3FFFFFFF;
            if (rly_ofs == TIMA_OFS) tima_r <= merge(tima_r, wb_dat_i, wb_sel_i) & 32'h03FF03FF;
            if (rly_ofs == TIMB_OFS) timb_r <= merge(timb_r, wb_dat_i, wb_sel_i) & 32'h03FF03FF;
         end
      end

      // State and timers freeze outside normal mode and carry on when it returns
      always_ff @(posedge clk_i) begin
         if (rst) begin
            st_r <= RLY_IDLE;
            tmr_r <= '0;
            acked_r <= 1'b0;
            relay_coil_o[i] <= 1'b0;
            relay_led_o[i] <= 1'b0;
         end else begin
            if (run) begin
               st_r <= st_nxt;
               if (st_nxt != st_r) begin
                  tmr_r <= '0;
               end else if (sec_tick && tmr_r != '1) begin
                  tmr_r <= tmr_r + 1'b1;
               end
               if (st_nxt != RLY_ACTIVE) begin
                  acked_r <= 1'b0;
               end else if (ack_pulse) begin
                  acked_r <= 1'b1;
               end
            end
            relay_coil_o[i] <= active_w[i] ^ cfg_r[CFG_NORM_ENERG];
            relay_led_o[i] <= active_w[i] ^ cfg_r[CFG_NORM_ENERG];
         end
      end
   end

   // ----------------------------------------
   // Communication line LEDs
   // ----------------------------------------
   for (genvar l = 0; l < NLINE; l++) begin : g_line
      logic tx_seen_r;
      logic rx_seen_r;

      always_ff @(posedge clk_i) begin
         if (rst) begin
            tx_seen_r <= 1'b0;
            rx_seen_r <= 1'b0;
            line_tx_led_o[l] <= 1'b0;
            line_rx_led_o[l] <= 1'b0;
         end else begin
            // New activity in the tick cycle wins over the clear
            tx_seen_r <= line_tx_act_i[l] | (tx_seen_r & ~fast_tick);
            rx_seen_r <= line_rx_act_i[l] | (rx_seen_r & ~fast_tick);
            if (!line_present_i[l]) begin
               line_tx_led_o[l] <= 1'b0;
               line_rx_led_o[l] <= 1'b0;
            end else if (line_fail_i[l]) begin
               line_tx_led_o[l] <= slow_phase_r;
               line_rx_led_o[l] <= 1'b0;
            end else if (fast_tick) begin
               if (line_poor_i[l]) begin
                  line_tx_led_o[l] <= line_tx_led_o[l] ^ lfsr_r[2*l];
                  line_rx_led_o[l] <= line_rx_led_o[l] ^ lfsr_r[2*l+1];
               end else begin
                  line_tx_led_o[l] <= tx_seen_r & ~line_tx_led_o[l];
                  line_rx_led_o[l] <= rx_seen_r & ~line_rx_led_o[l];
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Fault relay, buzzer and indicators
   // ----------------------------------------
   logic alarm_any;
   logic alarm_d_r;
   logic new_alarm;

   assign any_line_fail = |(line_fail_i & line_present_i);
   assign alarm_any = |active_w;
   assign new_alarm = alarm_any & ~alarm_d_r;

   always_ff @(posedge clk_i) begin
      if (rst) begin
         alarm_d_r <= 1'b0;
         buzz_pend_r <= 1'b0;
         fault_relay_o <= 1'b0;
         buzzer_o <= 1'b0;
         fail_led_o <= 1'b0;
         grayscale_o <= 1'b0;
         mode_o <= MODE_NORMAL;
      end else begin
         alarm_d_r <= alarm_any;
         // A fresh alarm in the acknowledge cycle keeps the buzzer pending
         buzz_pend_r <= new_alarm | (buzz_pend_r & ~ack_pulse);
         // Fault relay is held energized while healthy so a supply loss also trips it
         fault_relay_o <= ~any_line_fail;
         buzzer_o <= any_line_fail | buzz_pend_r;
         fail_led_o <= any_line_fail;
         grayscale_o <= shown_chan_alarm_i;
         mode_o <= mode_r;
      end
   end
endmodule

/* File: alarm_pkg.sv */
package alarm_pkg;
   // ----------------------------------------
   // Register map (byte offsets)
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] RELAY_BASE = 8'h20;
   localparam int RELAY_STRIDE_LG2 = 5;
   localparam logic [4:0] CFG_OFS = 5'h00;
   localparam logic [4:0] MASK_OFS = 5'h04;
   localparam logic [4:0] EQN_OFS = 5'h08;
   localparam logic [4:0] TIMA_OFS = 5'h0C;
   localparam logic [4:0] TIMB_OFS = 5'h10;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTRL_AUTO_ACK = 0;
   localparam int CFG_NORM_ENERG = 0;
   localparam int CFG_BUZZER = 1;
   localparam int CFG_LATCH = 2;
   localparam int CFG_SRC_LO = 3;
   localparam int CFG_FAULT_CNT = 5;
   localparam int CFG_VOTE_LO = 8;
   localparam int TIM_LO_LO = 0;
   localparam int TIM_HI_LO = 16;
   localparam int TIM_W = 10;
   localparam int ST_MODE_LO = 0;
   localparam int ST_ACTIVE_LO = 4;
   localparam int ST_FAIL_LO = 8;
   localparam int ST_BUZZ = 10;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int MS_PER_SEC = 1000;
   localparam int FAST_BLINK_MS = 50;
   localparam int SLOW_HALF_MS = 500;
   localparam logic [9:0] HOLD_MAX_S = 10'h384;
   localparam logic [9:0] AUTO_MIN_S = 10'h00F;
   localparam logic [9:0] AUTO_MAX_S = 10'h384;
   localparam logic [7:0] LFSR_SEED = 8'hA5;
   // ----------------------------------------
   // Enumerations
   // ----------------------------------------
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_CONFIG = 2'b01,
      MODE_UPDATE = 2'b10
   } op_mode_t;
   typedef enum logic [1:0] {
      SRC_OR = 2'b00,
      SRC_EQUATION = 2'b01,
      SRC_VOTING = 2'b10
   } relay_src_t;
   typedef enum logic [1:0] {
      OP_OR = 2'b00,
      OP_AND = 2'b01,
      OP_NOR = 2'b10,
      OP_NAND = 2'b11
   } gate_op_t;
   typedef enum logic [1:0] {
      RLY_IDLE = 2'b00,
      RLY_DELAY = 2'b01,
      RLY_ACTIVE = 2'b10,
      RLY_SILENT = 2'b11
   } relay_state_t;
endpackage

/* File: alarm_relay_sequencer_asserts.sv */
`timescale 1ns/1ns
module relay_seq_checker
   import alarm_pkg::*;
#(
   parameter int NRLY = 4,
   parameter int NLINE = 2
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ctrl_reset_btn_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Controls and lines
   input wire logic [1:0] selector_i,
   input wire logic shown_chan_alarm_i,
   input wire logic [NLINE-1:0] line_present_i,
   input wire logic [NLINE-1:0] line_fail_i,
   // Indicators
   input wire logic [NRLY-1:0] relay_coil_o,
   input wire logic [NRLY-1:0] relay_led_o,
   input wire logic fault_relay_o,
   input wire logic buzzer_o,
   input wire logic fail_led_o,
   input wire logic grayscale_o,
   input wire logic [1:0] mode_o,
   input wire logic [NLINE-1:0] line_tx_led_o,
   input wire logic [NLINE-1:0] line_rx_led_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || ctrl_reset_btn_i);
   // ----------------------------------------
   // Decodes
   // ----------------------------------------
   wire line_down = |(line_present_i & line_fail_i);
   wire line0_down = line_present_i[0] && line_fail_i[0];
   // Position 3 is read as configuration
   wire [1:0] mode_exp = (selector_i == 2'h3) ? 2'h1 : selector_i;

   ack_after_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not acknowledged one cycle later");
   ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus acknowledge longer than one cycle");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside acknowledge");
   mode_decode_a: assert property ($stable(selector_i) [*3] |-> mode_o == mode_exp)
      else $error("operating mode does not follow selector");
   led_follows_a: assert property (relay_led_o == relay_coil_o)
      else $error("relay status light differs from coil");
   gray_follow_a: assert property ($changed(shown_chan_alarm_i) |=> grayscale_o == $past(shown_chan_alarm_i))
      else $error("grayscale does not follow shown channel alarm");
   line_fault_a: assert property (line_down [*3] |-> !fault_relay_o && buzzer_o && fail_led_o)
      else $error("line failure not signalled on all fault outputs");
   fail_rx_a: assert property (line0_down [*3] |-> !line_rx_led_o[0])
      else $error("receive light lit on failed line");
   absent_off_a: assert property ((!line_present_i[0]) [*3] |-> !(line_tx_led_o[0] || line_rx_led_o[0]))
      else $error("line lights lit with no module present");

   cover property (relay_coil_o[0]);
   cover property (line_down && buzzer_o);
   cover property (grayscale_o);
endmodule

bind alarm_relay_sequencer relay_seq_checker #(.NRLY(NRLY), .NLINE(NLINE)) i_chk (
   .clk_i(clk_i), .rst_i(rst_i), .ctrl_reset_btn_i(ctrl_reset_btn_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .selector_i(selector_i), .shown_chan_alarm_i(shown_chan_alarm_i),
   .line_present_i(line_present_i), .line_fail_i(line_fail_i),
   .relay_coil_o(relay_coil_o), .relay_led_o(relay_led_o), .fault_relay_o(fault_relay_o),
   .buzzer_o(buzzer_o), .fail_led_o(fail_led_o), .grayscale_o(grayscale_o), .mode_o(mode_o),
   .line_tx_led_o(line_tx_led_o), .line_rx_led_o(line_rx_led_o)
);

/* File: line_partner.sv */
`timescale 1ns/1ns
module line_partner (
   // Clock and scenario control, two bits a line
   input wire logic clk_i,
   input wire logic [3:0] cond_i,
   input wire logic contact_i,
   // Line status towards the controller
   output logic [1:0] present_o,
   output logic [1:0] fail_o,
   output logic [1:0] poor_o,
   output logic [1:0] tx_o,
   output logic [1:0] rx_o,
   output logic closed_o
);
   logic [5:0] cnt_r = 6'h00;
   wire [1:0] up = {cond_i[3:2] != 2'h0, cond_i[1:0] != 2'h0};
   wire [1:0] dead = {cond_i[3:2] == 2'h3, cond_i[1:0] == 2'h3};
   always_ff @(posedge clk_i) begin
      cnt_r <= cnt_r + 6'h01;
   end
   assign present_o = up;
   assign fail_o = dead;
   assign poor_o = {cond_i[3:2] == 2'h2, cond_i[1:0] == 2'h2};
   // Queries go out on live lines; a failed module never answers
   assign tx_o = (cnt_r == 6'h00) ? up : 2'b00;
   assign rx_o = (cnt_r == 6'h01) ? (up & ~dead) : 2'b00;
   // Normally-open dry contact: closed only while pressed
   assign closed_o = contact_i;
endmodule

/* File: alarm_relay_sequencer_tb_top.sv */
`timescale 1ns/1ns
module alarm_relay_sequencer_tb_top;
   typedef struct {logic [1:0] s; logic [1:0] m;} row_t;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic btn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack_l = 1'b0, contact = 1'b0, shown = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rd;
   logic [1:0] sel = 2'h0;
   logic [3:0] be = 4'h0;
   logic [3:0] cond = 4'h0;
   logic [15:0] alarm = 16'h0;
   logic [2:0] seen;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, fault_relay_o, buzzer_o, fail_led_o, grayscale_o, closed;
   wire [3:0] coil, led;
   wire [1:0] mode_o, present, fail, poor, tx, rx, tx_led, rx_led;
   int n_fail = 0;
   int num_checks = 0;
   row_t rows [4] = '{'{2'h0, 2'h0}, '{2'h1, 2'h1}, '{2'h2, 2'h2}, '{2'h3, 2'h1}};

   alarm_relay_sequencer #(.MS_CYCLES(4)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(be), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .selector_i(sel), .ctrl_reset_btn_i(btn), .ack_local_i(ack_l), .ack_remote_closed_i(closed),
      .shown_chan_alarm_i(shown), .alarm_evt_i(alarm), .fault_evt_i(16'h0000),
      .line_present_i(present), .line_fail_i(fail), .line_poor_i(poor), .line_tx_act_i(tx),
      .line_rx_act_i(rx), .relay_coil_o(coil), .relay_led_o(led), .fault_relay_o(fault_relay_o),
      .buzzer_o(buzzer_o), .fail_led_o(fail_led_o), .grayscale_o(grayscale_o), .mode_o(mode_o),
      .line_tx_led_o(tx_led), .line_rx_led_o(rx_led)
   );
   line_partner i_line (.clk_i(clk_i), .cond_i(cond), .contact_i(contact), .present_o(present),
      .fail_o(fail), .poor_o(poor), .tx_o(tx), .rx_o(rx), .closed_o(closed));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic final_report;
      if (n_fail == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic go(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      be <= 4'hF;
      i = 0;
      do begin
         @(posedge clk_i);
         i++;
      end while (wb_ack_o !== 1'b1 && i < 50);
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      be <= 4'h0;
      if (i >= 50) begin
         n_fail++;
         final_report();
      end
   endtask
   // Coil settles within a few cycles when delay and hold are zero
   task automatic wait_coil(input logic [3:0] e);
      for (int i = 0; i < 100 && coil !== e; i++) @(posedge clk_i);
      cmp("coil", {28'h0, e}, {28'h0, coil});
   endtask
   // Bits: receive seen lit, transmit seen dark, transmit seen lit
   task automatic watch(input int n);
      seen = 3'b000;
      repeat (n) begin
         @(posedge clk_i);
         seen |= {rx_led[0], ~tx_led[0], tx_led[0]};
      end
   endtask

   initial begin
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      go(4);
      cmp("coil_in_reset", 32'h0, {28'h0, coil});
      rst_i <= 1'b0;
      go(3);
      cmp("fault_relay", 32'h1, {31'h0, fault_relay_o});
      bus(1'b1, 8'h00, 32'h1);
      foreach (rows[k]) begin
         sel <= rows[k].s;
         go(3);
         cmp("mode", {30'h0, rows[k].m}, {30'h0, mode_o});
      end
      bus(1'b0, 8'h00, 32'h0);
      cmp("ctrl_refused", 32'h0, rd);
      bus(1'b0, 8'hFC, 32'h0);
      cmp("unmapped", 32'h0, rd);
      bus(1'b1, 8'h24, 32'h1);
      bus(1'b1, 8'h40, 32'h1);
      bus(1'b1, 8'h60, 32'h2);
      bus(1'b1, 8'h64, 32'h2);
      bus(1'b0, 8'h40, 32'h0);
      cmp("cfg_read", 32'h1, rd);
      sel <= 2'h0;
      wait_coil(4'b0010);
      alarm <= 16'h0001;
      wait_coil(4'b0011);
      cmp("led", 32'h3, {28'h0, led});
      alarm <= 16'h0000;
      wait_coil(4'b0010);
      cmp("buzzer_on", 32'h1, {31'h0, buzzer_o});
      contact <= 1'b1;
      go(3);
      cmp("buzzer_remote", 32'h0, {31'h0, buzzer_o});
      contact <= 1'b0;
      alarm <= 16'h0002;
      wait_coil(4'b0110);
      ack_l <= 1'b1;
      go(2);
      ack_l <= 1'b0;
      wait_coil(4'b0010);
      cmp("buzzer_local", 32'h0, {31'h0, buzzer_o});
      alarm <= 16'h0000;
      shown <= 1'b1;
      go(2);
      cmp("grayscale", 32'h1, {31'h0, grayscale_o});
      shown <= 1'b0;
      cond <= 4'h1;
      watch(1000);
      cmp("line_normal", 32'h7, {29'h0, seen});
      cond <= 4'h3;
      go(10);
      cmp("fault_outs", 32'h3, {29'h0, fault_relay_o, buzzer_o, fail_led_o});
      watch(8000);
      cmp("line_fail", 32'h3, {29'h0, seen});
      cond <= 4'h2;
      watch(2000);
      cmp("line_poor", 32'h7, {29'h0, seen});
      cond <= 4'h0;
      go(5);
      watch(500);
      cmp("line_absent", 32'h2, {29'h0, seen});
      cmp("line1_off", 32'h0, {30'h0, tx_led[1], rx_led[1]});
      // Relay 0: latched, event 0 AND event 1; relay 1: two of events 0..2
      sel <= 2'h1;
      bus(1'b1, 8'h20, 32'h0000000C);
      bus(1'b1, 8'h24, 32'h00000003);
      bus(1'b1, 8'h28, 32'h00004000);
      bus(1'b1, 8'h40, 32'h00000211);
      bus(1'b1, 8'h44, 32'h00000007);
      sel <= 2'h0;
      alarm <= 16'h0001;
      go(20);
      cmp("one_of_two", 32'h2, {28'h0, coil});
      alarm <= 16'h0003;
      wait_coil(4'b0101);
      alarm <= 16'h0000;
      go(20);
      cmp("latched", 32'h3, {28'h0, coil});
      bus(1'b0, 8'h04, 32'h0);
      cmp("status", 32'h410, rd);
      ack_l <= 1'b1;
      go(2);
      ack_l <= 1'b0;
      wait_coil(4'b0010);
      sel <= 2'h1;
      bus(1'b1, 8'h00, 32'h1);
      sel <= 2'h0;
      alarm <= 16'h0003;
      wait_coil(4'b0101);
      alarm <= 16'h0000;
      wait_coil(4'b0010);
      cmp("buzzer_auto", 32'h1, {31'h0, buzzer_o});
      btn <= 1'b1;
      go(2);
      btn <= 1'b0;
      go(2);
      cmp("coil_button", 32'h0, {28'h0, coil});
      final_report();
   end
endmodule
